// ===== mlie_core.sv
// execution core for literal moves, accumulator stores and indirect pointer accesses
`timescale 1ns/1ps
module mlie_core (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  output logic instr_ready_o,
  input wire logic [7:0] mem_rdata_i,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_we_o,
  output logic mem_re_o,
  output logic [7:0] acc_o,
  output logic [4:0] bank_select_reg_o,
  output logic [6:0] pc_high_latch_o,
  output logic [7:0] timer_cfg_o,
  output logic [15:0] file_select_pointer0_o,
  output logic [15:0] file_select_pointer1_o,
  output logic zero_flag_o,
  output logic reset_instr_flag_n_o,
  output logic soft_reset_o,
  output logic pc_advance_o
);

  typedef enum {ST_EXEC, ST_LOAD_WAIT} mlie_state_t;

  mlie_state_t state_ff;
  mlie_pkg::mlie_op_t op;
  logic exec;
  logic [7:0] acc_ff;
  logic [4:0] bank_ff;
  logic [6:0] page_ff;
  logic [7:0] tcfg_ff;
  logic [15:0] ptr0_ff;
  logic [15:0] ptr1_ff;
  logic zero_ff;
  logic rst_flag_n_ff;
  logic soft_rst_ff;
  logic adv_ff;
  logic [15:0] mem_addr_ff;
  logic [7:0] mem_wdata_ff;
  logic mem_we_ff;
  logic mem_re_ff;
  logic ind_op;
  logic k_form;
  logic ptr_sel;
  logic [15:0] sel_ptr;
  logic [15:0] eff_addr;
  logic [15:0] nxt_ptr;
  logic [6:0] file_adr;
  logic [15:0] direct_addr;

  // ------------------------------------------------------------------
  // decode
  // ------------------------------------------------------------------
  assign op = mlie_pkg::mlie_decode(instr_i);
  assign instr_ready_o = (state_ff == ST_EXEC);
  assign exec = instr_valid_i && instr_ready_o;
  assign ind_op = (op == mlie_pkg::MLIE_OP_STIND) || (op == mlie_pkg::MLIE_OP_LDIND) ||
                  (op == mlie_pkg::MLIE_OP_STIND_K) || (op == mlie_pkg::MLIE_OP_LDIND_K);
  assign k_form = (op == mlie_pkg::MLIE_OP_STIND_K) || (op == mlie_pkg::MLIE_OP_LDIND_K);
  assign file_adr = instr_i[6:0];

  assign ptr_sel = k_form ? instr_i[mlie_pkg::FLD_SEL_K] : instr_i[mlie_pkg::FLD_SEL_SHORT];
  assign sel_ptr = ptr_sel ? ptr1_ff : ptr0_ff;
  assign direct_addr = {4'h0, bank_ff, file_adr};

  mlie_ptr_unit u_ptr (
    .ptr_i(sel_ptr),
    .mode_i(instr_i[1:0]),
    .offset_form_i(k_form),
    .offset_i(instr_i[5:0]),
    .eff_addr_o(eff_addr),
    .nxt_ptr_o(nxt_ptr)
  );

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_EXEC;
    end else begin
      case (state_ff)
        ST_EXEC: begin
          if (exec && ((op == mlie_pkg::MLIE_OP_LDIND) ||
                       (op == mlie_pkg::MLIE_OP_LDIND_K))) begin
            state_ff <= ST_LOAD_WAIT;
          end
        end
        ST_LOAD_WAIT: begin
          state_ff <= ST_EXEC;
        end
        default: begin
          state_ff <= ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      adv_ff <= 1'b0;
    end else begin
      adv_ff <= exec && (op != mlie_pkg::MLIE_OP_SWRST);
    end
  end

  // soft reset pulse and cause flag
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_rst_ff <= 1'b0;
      rst_flag_n_ff <= 1'b1;
    end else begin
      soft_rst_ff <= exec && (op == mlie_pkg::MLIE_OP_SWRST);
      if (exec && (op == mlie_pkg::MLIE_OP_SWRST)) begin
        rst_flag_n_ff <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // literal and configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bank_ff <= mlie_pkg::RST_BANK;
      page_ff <= mlie_pkg::RST_PAGE;
      tcfg_ff <= mlie_pkg::RST_TCFG;
    end else if (exec && (op == mlie_pkg::MLIE_OP_SWRST)) begin
      bank_ff <= mlie_pkg::RST_BANK;
      page_ff <= mlie_pkg::RST_PAGE;
      tcfg_ff <= mlie_pkg::RST_TCFG;
    end else if (exec) begin
      if (op == mlie_pkg::MLIE_OP_LDBANK) bank_ff <= instr_i[4:0];
      if (op == mlie_pkg::MLIE_OP_LDPAGE) page_ff <= instr_i[6:0];
      if (op == mlie_pkg::MLIE_OP_TCFG) tcfg_ff <= acc_ff;
    end
  end

  // accumulator and zero flag
  // zero only from indirect loads; soft reset clears it
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_ff <= mlie_pkg::RST_ACC;
      zero_ff <= 1'b0;
    end else if (exec && (op == mlie_pkg::MLIE_OP_SWRST)) begin
      acc_ff <= mlie_pkg::RST_ACC;
      zero_ff <= 1'b0;
    end else if (state_ff == ST_LOAD_WAIT) begin
      acc_ff <= mem_rdata_i;
      zero_ff <= (mem_rdata_i == 8'h00);
    end else if (exec && (op == mlie_pkg::MLIE_OP_LDACC)) begin
      acc_ff <= instr_i[7:0];
    end
  end

  // ------------------------------------------------------------------
  // pointers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr0_ff <= mlie_pkg::RST_PTR;
      ptr1_ff <= mlie_pkg::RST_PTR;
    end else if (exec && (op == mlie_pkg::MLIE_OP_SWRST)) begin
      ptr0_ff <= mlie_pkg::RST_PTR;
      ptr1_ff <= mlie_pkg::RST_PTR;
    end else if (exec && ind_op) begin
      if (ptr_sel) ptr1_ff <= nxt_ptr;
      else ptr0_ff <= nxt_ptr;
    end else if (exec && (op == mlie_pkg::MLIE_OP_STFILE)) begin
      // pointer bytes are core file registers
      case (file_adr)
        mlie_pkg::ADR_PTR0_LO: ptr0_ff[7:0] <= acc_ff;
        mlie_pkg::ADR_PTR0_HI: ptr0_ff[15:8] <= acc_ff;
        mlie_pkg::ADR_PTR1_LO: ptr1_ff[7:0] <= acc_ff;
        mlie_pkg::ADR_PTR1_HI: ptr1_ff[15:8] <= acc_ff;
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // memory port
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_addr_ff <= 16'h0000;
      mem_wdata_ff <= 8'h00;
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
    end else begin
      mem_we_ff <= 1'b0;
      mem_re_ff <= 1'b0;
      if (exec) begin
        mem_wdata_ff <= acc_ff;
        case (op)
          mlie_pkg::MLIE_OP_STIND, mlie_pkg::MLIE_OP_STIND_K: begin
            mem_addr_ff <= eff_addr;
            mem_we_ff <= 1'b1;
          end
          mlie_pkg::MLIE_OP_LDIND, mlie_pkg::MLIE_OP_LDIND_K: begin
            mem_addr_ff <= eff_addr;
            mem_re_ff <= 1'b1;
          end
          mlie_pkg::MLIE_OP_STFILE: begin
            // port addresses go through the pointers
            if (file_adr == mlie_pkg::ADR_PORT0) begin
              mem_addr_ff <= ptr0_ff;
              mem_we_ff <= 1'b1;
            end else if (file_adr == mlie_pkg::ADR_PORT1) begin
              mem_addr_ff <= ptr1_ff;
              mem_we_ff <= 1'b1;
            end else if (file_adr > mlie_pkg::ADR_PTR1_HI) begin
              mem_addr_ff <= direct_addr;
              mem_we_ff <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  assign mem_addr_o = mem_addr_ff;
  assign mem_wdata_o = mem_wdata_ff;
  assign mem_we_o = mem_we_ff;
  assign mem_re_o = mem_re_ff;
  assign acc_o = acc_ff;
  assign bank_select_reg_o = bank_ff;
  assign pc_high_latch_o = page_ff;
  assign timer_cfg_o = tcfg_ff;
  assign file_select_pointer0_o = ptr0_ff;
  assign file_select_pointer1_o = ptr1_ff;
  assign zero_flag_o = zero_ff;
  assign reset_instr_flag_n_o = rst_flag_n_ff;
  assign soft_reset_o = soft_rst_ff;
  assign pc_advance_o = adv_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_ex(mlie_pkg::mlie_op_t o);
    exec && (op == o);
  endsequence

  property p_ldbank;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_LDBANK) |=> bank_select_reg_o == $past(instr_i[4:0]);
  endproperty
  a_ldbank: assert property (p_ldbank) else $error("bank literal not loaded");

  property p_ldpage;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_LDPAGE) |=> pc_high_latch_o == $past(instr_i[6:0]) && $stable(zero_flag_o);
  endproperty
  a_ldpage: assert property (p_ldpage) else $error("page latch literal not loaded");

  property p_ldacc;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_LDACC) |=> acc_o == $past(instr_i[7:0]) && $stable(zero_flag_o);
  endproperty
  a_ldacc: assert property (p_ldacc) else $error("accumulator literal not loaded");

  property p_stfile;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_STFILE) ##0 (instr_i[6:0] > 7'h07) |=>
        mem_we_o && mem_wdata_o == $past(acc_o) && mem_addr_o[6:0] == $past(instr_i[6:0]);
  endproperty
  a_stfile: assert property (p_stfile) else $error("file store missing");

  property p_tcfg;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_TCFG) |=> timer_cfg_o == $past(acc_o);
  endproperty
  a_tcfg: assert property (p_tcfg) else $error("timer configuration not loaded");

  property p_stind_addr;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_STIND) ##0 !instr_i[2] |=> mem_we_o &&
        mem_addr_o == $past(ptr0_ff + (instr_i[1] ? 16'h0000 : (instr_i[0] ? 16'hFFFF : 16'h0001)));
  endproperty
  a_stind_addr: assert property (p_stind_addr) else $error("indirect address wrong");

  property p_stind_ptr;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_STIND) ##0 instr_i[2] |=>
        file_select_pointer1_o == $past(ptr1_ff + (instr_i[0] ? 16'hFFFF : 16'h0001)) &&
        $stable(file_select_pointer0_o);
  endproperty
  a_stind_ptr: assert property (p_stind_ptr) else $error("pointer update wrong");

  property p_stind_k;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_STIND_K) |=> $stable(file_select_pointer0_o) &&
        $stable(file_select_pointer1_o) && $stable(zero_flag_o);
  endproperty
  a_stind_k: assert property (p_stind_k) else $error("offset form changed state");

  property p_swrst;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_SWRST) |=> soft_reset_o && !reset_instr_flag_n_o && acc_o == 8'h00
        ##1 (!soft_reset_o || $past(exec && (op == mlie_pkg::MLIE_OP_SWRST)));
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset not taken");

  sequence s_ld_read;
    s_ex(mlie_pkg::MLIE_OP_LDIND) ##1 (mem_re_o && !instr_ready_o);
  endsequence
  property p_ldind;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ld_read |=> acc_o == $past(mem_rdata_i) && zero_flag_o == ($past(mem_rdata_i) == 8'h00);
  endproperty
  a_ldind: assert property (p_ldind) else $error("indirect load result wrong");

  property p_nop;
    @(posedge clock_i) disable iff (!rst_n_i)
      s_ex(mlie_pkg::MLIE_OP_NOP) |=> pc_advance_o && !mem_we_o && $stable(acc_o) &&
        $stable(bank_select_reg_o) && $stable(file_select_pointer0_o);
  endproperty
  a_nop: assert property (p_nop) else $error("no-operation changed state");

endmodule

// ===== mlie_pkg.sv
// constants, opcode decode and pointer arithmetic for the move/indirect execution core
// Overview of operation
// - bank-load copies its 5-bit literal into the bank select register; flags untouched.
// - page-latch load copies its 7-bit literal into the pc high latch; flags untouched.
// - accumulator literal load puts the 8-bit literal into the accumulator; no flags.
// - store-to-file writes the accumulator to the 7-bit addressed file register; no flags.
// - timer configuration load copies the accumulator into timer configuration; no flags.
// - pointer mode field: 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - target is pointer+1 (pre-inc), pointer-1 (pre-dec), the pointer itself (post modes), or pointer plus signed offset -32..31.
// - afterwards the pointer is +1 for increments, -1 for decrements, else unchanged.
// - indirect port access goes to the location the matching pointer addresses.
// - each 16-bit pointer wraps modulo 0000h..FFFFh.
// - pointer updates of an indirect store leave all status flags unmodified.
// - software reset resets the core and clears the active-low reset-instruction flag.
// - indirect load uses same modes, moves location into accumulator, updates zero flag.
package mlie_pkg;

  typedef enum {
    MLIE_OP_NOP,
    MLIE_OP_LDBANK,
    MLIE_OP_LDPAGE,
    MLIE_OP_LDACC,
    MLIE_OP_STFILE,
    MLIE_OP_TCFG,
    MLIE_OP_STIND,
    MLIE_OP_LDIND,
    MLIE_OP_STIND_K,
    MLIE_OP_LDIND_K,
    MLIE_OP_SWRST,
    MLIE_OP_OTHER
  } mlie_op_t;

  // ----------------------------------------------------------------
  // opcode patterns (14-bit instruction word)
  // ----------------------------------------------------------------
  localparam logic [13:0] OPC_NOP = 14'h0000;
  localparam logic [13:0] OPC_SWRST = 14'h0001;
  localparam logic [13:0] OPC_TCFG = 14'h0062;
  localparam logic [13:0] MSK_LDBANK = 14'h3FE0;
  localparam logic [13:0] OPC_LDBANK = 14'h0020;
  localparam logic [13:0] MSK_LDPAGE = 14'h3F80;
  localparam logic [13:0] OPC_LDPAGE = 14'h3180;
  localparam logic [13:0] MSK_LDACC = 14'h3F00;
  localparam logic [13:0] OPC_LDACC = 14'h3000;
  localparam logic [13:0] MSK_STFILE = 14'h3F80;
  localparam logic [13:0] OPC_STFILE = 14'h0080;
  localparam logic [13:0] MSK_IND = 14'h3FF8;
  localparam logic [13:0] OPC_STIND = 14'h0018;
  localparam logic [13:0] OPC_LDIND = 14'h0010;
  localparam logic [13:0] MSK_IND_K = 14'h3F80;
  localparam logic [13:0] OPC_STIND_K = 14'h3F80;
  localparam logic [13:0] OPC_LDIND_K = 14'h3F00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLD_SEL_SHORT = 2;
  localparam int FLD_SEL_K = 6;

  // ----------------------------------------------------------------
  // pointer modes
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_PRE_INC = 2'h0;
  localparam logic [1:0] MODE_PRE_DEC = 2'h1;
  localparam logic [1:0] MODE_POST_INC = 2'h2;
  localparam logic [1:0] MODE_POST_DEC = 2'h3;

  // ----------------------------------------------------------------
  // core file addresses inside the 7-bit direct field
  // ----------------------------------------------------------------
  localparam logic [6:0] ADR_PORT0 = 7'h00;
  localparam logic [6:0] ADR_PORT1 = 7'h01;
  localparam logic [6:0] ADR_PTR0_LO = 7'h04;
  localparam logic [6:0] ADR_PTR0_HI = 7'h05;
  localparam logic [6:0] ADR_PTR1_LO = 7'h06;
  localparam logic [6:0] ADR_PTR1_HI = 7'h07;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ACC = 8'h00;
  localparam logic [4:0] RST_BANK = 5'h00;
  localparam logic [6:0] RST_PAGE = 7'h00;
  localparam logic [7:0] RST_TCFG = 8'hFF;
  localparam logic [15:0] RST_PTR = 16'h0000;

  function automatic mlie_op_t mlie_decode(input logic [13:0] ins);
    mlie_op_t op;
    op = MLIE_OP_OTHER;
    if (ins == OPC_NOP) op = MLIE_OP_NOP;
    else if (ins == OPC_SWRST) op = MLIE_OP_SWRST;
    else if (ins == OPC_TCFG) op = MLIE_OP_TCFG;
    else if ((ins & MSK_LDBANK) == OPC_LDBANK) op = MLIE_OP_LDBANK;
    else if ((ins & MSK_LDPAGE) == OPC_LDPAGE) op = MLIE_OP_LDPAGE;
    else if ((ins & MSK_LDACC) == OPC_LDACC) op = MLIE_OP_LDACC;
    else if ((ins & MSK_STFILE) == OPC_STFILE) op = MLIE_OP_STFILE;
    else if ((ins & MSK_IND) == OPC_STIND) op = MLIE_OP_STIND;
    else if ((ins & MSK_IND) == OPC_LDIND) op = MLIE_OP_LDIND;
    else if ((ins & MSK_IND_K) == OPC_STIND_K) op = MLIE_OP_STIND_K;
    else if ((ins & MSK_IND_K) == OPC_LDIND_K) op = MLIE_OP_LDIND_K;
    return op;
  endfunction

  // 6-bit signed offset extended to pointer width
  function automatic logic [15:0] mlie_sext6(input logic [5:0] k);
    return {{10{k[5]}}, k};
  endfunction

endpackage

// ------------------------------------------------------------------
// pointer address unit
// ------------------------------------------------------------------
`timescale 1ns/1ps
module mlie_ptr_unit (
  input wire logic [15:0] ptr_i,
  input wire logic [1:0] mode_i,
  input wire logic offset_form_i,
  input wire logic [5:0] offset_i,
  output logic [15:0] eff_addr_o,
  output logic [15:0] nxt_ptr_o
);
  always_comb begin
    case (mode_i)
      mlie_pkg::MODE_PRE_INC: begin
        eff_addr_o = ptr_i + 16'h0001;
        nxt_ptr_o = ptr_i + 16'h0001;
      end
      mlie_pkg::MODE_PRE_DEC: begin
        eff_addr_o = ptr_i - 16'h0001;
        nxt_ptr_o = ptr_i - 16'h0001;
      end
      mlie_pkg::MODE_POST_INC: begin
        eff_addr_o = ptr_i;
        nxt_ptr_o = ptr_i + 16'h0001;
      end
      default: begin
        eff_addr_o = ptr_i;
        nxt_ptr_o = ptr_i - 16'h0001;
      end
    endcase
    if (offset_form_i) begin
      eff_addr_o = ptr_i + mlie_pkg::mlie_sext6(offset_i);
      nxt_ptr_o = ptr_i;
    end
  end
endmodule

// ===== tb_move_literal_indirect_exec.sv
// self-checking bench for the move/indirect execution core
`timescale 1ns/1ps
module tb_move_literal_indirect_exec;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [13:0] instr_i = 14'h0000;
  logic [7:0] mem_rdata_i = 8'h00;
  logic instr_ready_o;
  logic mem_we_o;
  logic mem_re_o;
  logic zero_flag_o;
  logic reset_instr_flag_n_o;
  logic soft_reset_o;
  logic pc_advance_o;
  logic [15:0] mem_addr_o;
  logic [15:0] file_select_pointer0_o;
  logic [15:0] file_select_pointer1_o;
  logic [7:0] mem_wdata_o;
  logic [7:0] acc_o;
  logic [7:0] timer_cfg_o;
  logic [4:0] bank_select_reg_o;
  logic [6:0] pc_high_latch_o;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int m_acc, m_bank, m_page, m_tcfg, m_zero, m_flag_n;
  int m_ptr [2];
  int e_we, e_re, e_addr, e_wdata, e_srst, e_adv, e_ready;
  int pend [$];
  int dir [$] = {'h303B, 'h0084, 'h3000, 'h0085, 'h0010, 'h30FF, 'h0086, 'h0087,
    'h001E, 'h001D, 'h3FE0, 'h3F9F, 'h003F, 'h31FF, 'h0062, 'h00FF, 'h0080, 'h0081,
    'h0082, 'h0000, 'h3F7F, 'h0017, 'h0063, 'h0014, 'h001B, 'h0001};

  mlie_core mlie_core_inst (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .instr_ready_o(instr_ready_o),
    .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o),
    .mem_re_o(mem_re_o),
    .acc_o(acc_o),
    .bank_select_reg_o(bank_select_reg_o),
    .pc_high_latch_o(pc_high_latch_o),
    .timer_cfg_o(timer_cfg_o),
    .file_select_pointer0_o(file_select_pointer0_o),
    .file_select_pointer1_o(file_select_pointer1_o),
    .zero_flag_o(zero_flag_o),
    .reset_instr_flag_n_o(reset_instr_flag_n_o),
    .soft_reset_o(soft_reset_o),
    .pc_advance_o(pc_advance_o)
  );

  always #4 clock_i = ~clock_i;

  // ----------------------------------------------------------------
  // memory, timeout and reporting
  // ----------------------------------------------------------------
  function automatic int rd_byte(input int a);
    return ((a & 255) ^ ((a >> 8) & 255) ^ 'h3C) & 255;
  endfunction

  // read data only valid while the read strobe is up, otherwise it toggles
  always @(posedge clock_i) begin
    #1;
    if (mem_re_o === 1'b1) mem_rdata_i <= 8'(rd_byte(int'(mem_addr_o)));
    else mem_rdata_i <= ~mem_rdata_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total = err_total + 1;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input int exp, input logic [15:0] got);
    tests_run = tests_run + 1;
    if (got !== 16'(exp)) begin
      err_total = err_total + 1;
      $display("unexpected %s expected %h seen %h", nm, 16'(exp), got);
    end
  endtask

  // ----------------------------------------------------------------
  // reference model
  // ----------------------------------------------------------------
  task automatic m_reset(input int flag);
    m_acc = 0;
    m_bank = 0;
    m_page = 0;
    m_tcfg = 255;
    m_zero = 0;
    m_ptr[0] = 0;
    m_ptr[1] = 0;
    m_flag_n = flag;
  endtask

  task automatic ind(input int st);
    e_addr = e_addr & 'hFFFF;
    if (st != 0) begin
      e_we = 1;
    end else begin
      e_re = 1;
      e_ready = 0;
      pend.push_back(rd_byte(e_addr));
    end
  endtask

  task automatic m_exec(input int ins);
    int sel;
    int md;
    int p;
    int f;
    e_we = 0;
    e_re = 0;
    e_srst = 0;
    e_adv = 1;
    e_ready = 1;
    e_wdata = m_acc;
    e_addr = 0;
    if (ins == 1) begin
      m_reset(0);
      e_srst = 1;
      e_adv = 0;
    end else if (ins == 'h62) begin
      m_tcfg = m_acc;
    end else if ((ins & 'h3FE0) == 'h20) begin
      m_bank = ins & 31;
    end else if ((ins & 'h3F80) == 'h3180) begin
      m_page = ins & 127;
    end else if ((ins & 'h3F00) == 'h3000) begin
      m_acc = ins & 255;
    end else if ((ins & 'h3F80) == 'h80) begin
      f = ins & 127;
      p = (f >> 1) & 1;
      e_we = (f < 2 || f > 7) ? 1 : 0;
      e_addr = (f < 2) ? m_ptr[f] : m_bank * 128 + f;
      if (f == 4 || f == 6) m_ptr[p] = (m_ptr[p] & 'hFF00) | m_acc;
      if (f == 5 || f == 7) m_ptr[p] = (m_ptr[p] & 'hFF) | (m_acc << 8);
    end else if ((ins & 'h3FF0) == 'h10) begin
      sel = (ins >> 2) & 1;
      md = ins & 3;
      p = m_ptr[sel];
      e_addr = (md == 0) ? p + 1 : (md == 1) ? p - 1 : p;
      m_ptr[sel] = ((md & 1) != 0) ? (p + 'hFFFF) & 'hFFFF : (p + 1) & 'hFFFF;
      ind(ins & 8);
    end else if ((ins & 'h3F00) == 'h3F00) begin
      sel = (ins >> 6) & 1;
      f = ins & 63;
      e_addr = m_ptr[sel] + f - (((f & 32) != 0) ? 64 : 0);
      ind(ins & 'h80);
    end
  endtask

  // ----------------------------------------------------------------
  // comparison and stimulus
  // ----------------------------------------------------------------
  task automatic chk_all;
    chk("ready", e_ready, 16'(instr_ready_o));
    chk("we", e_we, 16'(mem_we_o));
    chk("re", e_re, 16'(mem_re_o));
    if (e_we + e_re > 0) chk("addr", e_addr, mem_addr_o);
    if (e_we > 0) chk("wdata", e_wdata, 16'(mem_wdata_o));
    chk("acc", m_acc, 16'(acc_o));
    chk("bank", m_bank, 16'(bank_select_reg_o));
    chk("page", m_page, 16'(pc_high_latch_o));
    chk("tcfg", m_tcfg, 16'(timer_cfg_o));
    chk("ptr0", m_ptr[0], file_select_pointer0_o);
    chk("ptr1", m_ptr[1], file_select_pointer1_o);
    chk("zero", m_zero, 16'(zero_flag_o));
    chk("flag_n", m_flag_n, 16'(reset_instr_flag_n_o));
    chk("srst", e_srst, 16'(soft_reset_o));
    chk("adv", e_adv, 16'(pc_advance_o));
  endtask

  task automatic idle_chk;
    e_we = 0;
    e_re = 0;
    e_srst = 0;
    e_adv = 0;
    e_ready = 1;
    chk_all();
  endtask

  // called just after a rising edge; leaves valid up for back-to-back issue except after an indirect load
  task automatic run(input int ins);
    instr_i = 14'(ins);
    instr_valid_i = 1'b1;
    @(posedge clock_i);
    #1;
    m_exec(ins);
    chk_all();
    if (e_re > 0) begin
      instr_valid_i = 1'b0;
      @(posedge clock_i);
      #1;
      m_acc = pend.pop_front();
      m_zero = (m_acc == 0) ? 1 : 0;
      idle_chk();
    end
  endtask

  function automatic int rnd_ins();
    int b [11] = '{'h0000, 'h0020, 'h3180, 'h3000, 'h0080, 'h0062, 'h0018, 'h0010,
      'h3F80, 'h3F00, 0};
    int m [11] = '{0, 31, 127, 255, 127, 0, 7, 7, 127, 127, 'h3FFF};
    int k;
    k = $urandom % 11;
    return b[k] | ($urandom & m[k]);
  endfunction

  initial begin
    void'($urandom(32'hA663));
    m_reset(1);
    repeat (5) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    idle_chk();
    // wrap, zero result, every mode and soft reset
    foreach (dir[i]) run(dir[i]);
    repeat (300) run(rnd_ins());
    instr_valid_i = 1'b0;
    @(posedge clock_i);
    #1;
    rst_n_i = 1'b0;
    #2;
    m_reset(1);
    pend.delete();
    idle_chk();
    @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    repeat (60) run(rnd_ins());
    test_done();
  end
endmodule
